// >>> rtl/hsg_map.svh
/*
  register indices, field positions, reset values and timing figures
  of the haptic signal generator; definitions only
*/
`ifndef HSG_MAP_SVH
`define HSG_MAP_SVH

// register indices; byte address is four times the index
`define HSG_IDX_CONTROL 8'h90
`define HSG_IDX_FREQ 8'h91
`define HSG_IDX_P1_LEVEL 8'h92
`define HSG_IDX_P1_LENGTH 8'h93
`define HSG_IDX_P2_LEVEL 8'h94
`define HSG_IDX_P2_LENGTH 8'h95
`define HSG_IDX_P3_LEVEL 8'h96
`define HSG_IDX_P3_LENGTH 8'h97
`define HSG_IDX_STATUS 8'h98
`define HSG_IDX_RATE 8'h99

// control fields
`define HSG_ACT_BIT 0
`define HSG_MODE_HI 3
`define HSG_MODE_LO 2
`define HSG_TRIG_BIT 4

// reset values
`define HSG_FREQ_RST 15'h7fff
`define HSG_RATE_RST 16'h00d0

// source code the mixer uses to pick this generator
`define HSG_MIXER_SRC 8'h06

// timing: step of a phase length and the clocks involved
`define HSG_STEP_NS 625000
`define HSG_CLK_NS 100
`define HSG_SYS_KHZ 14'h2710
`define HSG_BASE_KHZ 14'h1800

`endif

// >>> rtl/hsg_pkg.sv
/*
  types of the haptic signal generator
  assumes hsg_map.svh for numeric constants
*/
package hsg_pkg;
    typedef enum logic [1:0] {
        HSG_MODE_OFF = 2'h0,
        HSG_MODE_CONT = 2'h1,
        HSG_MODE_SHOT = 2'h2,
        HSG_MODE_RSVD = 2'h3
    } hsg_mode_t;
    typedef enum logic [1:0] {HSG_IDLE, HSG_PH1, HSG_PH2, HSG_PH3} hsg_state_t;
    typedef logic signed [15:0] hsg_sample_t;
endpackage

// >>> rtl/hsg_top.sv
/*
  haptic signal generator: wishbone classic register slave, three-phase
  one-shot sequencer, dc or square tone sample source, sample fifo.
  assumes one clock clk_sys at 10 MHz and a mixer that drains samples
  over valid/ready on the same clock.
*/
`include "hsg_map.svh"
`timescale 1ns/100ps
`default_nettype none

module hsg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    assign in_ready = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
            rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module hsg_top #(
    // clocks per 0.625 ms length step; shorten in simulation
    parameter int STEP_CYCLES = `HSG_STEP_NS / `HSG_CLK_NS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // sample stream to the output mixer
    output hsg_pkg::hsg_sample_t mix_data,
    output logic mix_valid,
    input wire logic mix_ready
);
    import hsg_pkg::*;

    // registers
    logic act_sel;
    hsg_mode_t vibe_mode_select;
    logic [14:0] resonant_freq_divider;
    logic [7:0] first_stage_level;
    logic [7:0] middle_stage_level;
    logic [7:0] final_stage_level;
    logic [8:0] first_stage_length;
    logic [10:0] middle_stage_length;
    logic [8:0] final_stage_length;
    logic [15:0] vibe_sample_rate_sel;

    // bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire [7:0] reg_idx = wb_adr_i[9:2];
    wire lane0 = wb_sel_i[0];
    wire lane1 = wb_sel_i[1];
    wire wr_ctrl = bus_wr && reg_idx == `HSG_IDX_CONTROL && lane0;
    wire wr_freq = bus_wr && reg_idx == `HSG_IDX_FREQ;
    wire wr_p1l = bus_wr && reg_idx == `HSG_IDX_P1_LEVEL && lane0;
    wire wr_p1n = bus_wr && reg_idx == `HSG_IDX_P1_LENGTH;
    wire wr_p2l = bus_wr && reg_idx == `HSG_IDX_P2_LEVEL && lane0;
    wire wr_p2n = bus_wr && reg_idx == `HSG_IDX_P2_LENGTH;
    wire wr_p3l = bus_wr && reg_idx == `HSG_IDX_P3_LEVEL && lane0;
    wire wr_p3n = bus_wr && reg_idx == `HSG_IDX_P3_LENGTH;
    wire wr_rate = bus_wr && reg_idx == `HSG_IDX_RATE;
    wire trig_wr = wr_ctrl && wb_dat_i[`HSG_TRIG_BIT];
    // only one-shot mode honours the trigger
    wire trig_go = trig_wr && vibe_mode_select == HSG_MODE_SHOT;

    // sequencer state
    hsg_state_t state;
    hsg_state_t next_state;
    logic [10:0] steps_left;
    logic [10:0] next_steps;
    logic [15:0] step_div;
    wire step_done = step_div == 16'(STEP_CYCLES - 1);
    wire profile_active_flag = state != HSG_IDLE;

    // read mux; trigger bit reads as zero
    wire [15:0] rd_ctrl = {12'h000, 1'b0, vibe_mode_select, act_sel};
    wire [15:0] rd_mux =
        reg_idx == `HSG_IDX_CONTROL ? rd_ctrl :
        reg_idx == `HSG_IDX_FREQ ? {1'b0, resonant_freq_divider} :
        reg_idx == `HSG_IDX_P1_LEVEL ? {8'h00, first_stage_level} :
        reg_idx == `HSG_IDX_P1_LENGTH ? {7'h00, first_stage_length} :
        reg_idx == `HSG_IDX_P2_LEVEL ? {8'h00, middle_stage_level} :
        reg_idx == `HSG_IDX_P2_LENGTH ? {5'h00, middle_stage_length} :
        reg_idx == `HSG_IDX_P3_LEVEL ? {8'h00, final_stage_level} :
        reg_idx == `HSG_IDX_P3_LENGTH ? {7'h00, final_stage_length} :
        reg_idx == `HSG_IDX_STATUS ? {15'h0000, profile_active_flag} :
        reg_idx == `HSG_IDX_RATE ? vibe_sample_rate_sel : 16'h0000;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req && !wb_we_i ? {16'h0000, rd_mux} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            act_sel <= 1'b0;
            vibe_mode_select <= HSG_MODE_OFF;
        end else if (wr_ctrl) begin
            act_sel <= wb_dat_i[`HSG_ACT_BIT];
            vibe_mode_select <= hsg_mode_t'(wb_dat_i[`HSG_MODE_HI:`HSG_MODE_LO]);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            resonant_freq_divider <= `HSG_FREQ_RST;
            first_stage_level <= 8'h00;
            middle_stage_level <= 8'h00;
            final_stage_level <= 8'h00;
            first_stage_length <= 9'h000;
            middle_stage_length <= 11'h000;
            final_stage_length <= 9'h000;
            vibe_sample_rate_sel <= `HSG_RATE_RST;
        end else begin
            if (wr_freq && lane0) resonant_freq_divider[7:0] <= wb_dat_i[7:0];
            if (wr_freq && lane1) resonant_freq_divider[14:8] <= wb_dat_i[14:8];
            if (wr_p1l) first_stage_level <= wb_dat_i[7:0];
            if (wr_p2l) middle_stage_level <= wb_dat_i[7:0];
            if (wr_p3l) final_stage_level <= wb_dat_i[7:0];
            if (wr_p1n && lane0) first_stage_length[7:0] <= wb_dat_i[7:0];
            if (wr_p1n && lane1) first_stage_length[8] <= wb_dat_i[8];
            if (wr_p2n && lane0) middle_stage_length[7:0] <= wb_dat_i[7:0];
            if (wr_p2n && lane1) middle_stage_length[10:8] <= wb_dat_i[10:8];
            if (wr_p3n && lane0) final_stage_length[7:0] <= wb_dat_i[7:0];
            if (wr_p3n && lane1) final_stage_length[8] <= wb_dat_i[8];
            if (wr_rate && lane0) vibe_sample_rate_sel[7:0] <= wb_dat_i[7:0];
            if (wr_rate && lane1) vibe_sample_rate_sel[15:8] <= wb_dat_i[15:8];
        end
    end

    // phase sequencing; a phase ends when its steps run out
    always_comb begin
        next_state = state;
        next_steps = steps_left;
        case (state)
            HSG_IDLE: begin
                next_steps = 11'h000;
            end
            HSG_PH1: begin
                if (steps_left == 11'h000) begin
                    next_state = HSG_PH2;
                    next_steps = middle_stage_length;
                end else if (step_done) begin
                    next_steps = steps_left - 11'h001;
                end
            end
            HSG_PH2: begin
                if (steps_left == 11'h000) begin
                    next_state = HSG_PH3;
                    next_steps = {2'b00, final_stage_length};
                end else if (step_done) begin
                    next_steps = steps_left - 11'h001;
                end
            end
            HSG_PH3: begin
                if (steps_left == 11'h000) begin
                    next_state = HSG_IDLE;
                end else if (step_done) begin
                    next_steps = steps_left - 11'h001;
                end
            end
            default: begin
                next_state = HSG_IDLE;
                next_steps = 11'h000;
            end
        endcase
        // a retrigger restarts the profile; leaving one-shot aborts it
        if (trig_go) begin
            next_state = HSG_PH1;
            next_steps = {2'b00, first_stage_length};
        end else if (vibe_mode_select != HSG_MODE_SHOT) begin
            next_state = HSG_IDLE;
        end
    end

    wire phase_change = trig_go || next_state != state;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state <= HSG_IDLE;
            steps_left <= 11'h000;
            step_div <= 16'h0000;
        end else begin
            state <= next_state;
            steps_left <= next_steps;
            step_div <= phase_change || step_done ? 16'h0000 : step_div + 16'h0001;
        end
    end

    // base clock ticks by a fractional accumulator, no second clock
    logic [13:0] base_acc;
    logic [14:0] half_cnt;
    logic tone_pol;
    wire [13:0] acc_sum = base_acc + `HSG_BASE_KHZ;
    wire base_tick = acc_sum >= `HSG_SYS_KHZ;
    wire half_done = base_tick && half_cnt >= resonant_freq_divider;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            base_acc <= 14'h0000;
            half_cnt <= 15'h0000;
            tone_pol <= 1'b0;
        end else begin
            base_acc <= base_tick ? acc_sum - `HSG_SYS_KHZ : acc_sum;
            if (half_done) begin
                half_cnt <= 15'h0000;
                tone_pol <= !tone_pol;
            end else if (base_tick) begin
                half_cnt <= half_cnt + 15'h0001;
            end
        end
    end

    wire [7:0] shot_level =
        state == HSG_PH1 ? first_stage_level :
        state == HSG_PH2 ? middle_stage_level :
        state == HSG_PH3 ? final_stage_level : 8'h00;
    wire [7:0] act_level =
        vibe_mode_select == HSG_MODE_CONT ? middle_stage_level :
        vibe_mode_select == HSG_MODE_SHOT ? shot_level : 8'h00;
    // dc level at full scale; square tone, sign flips phase
    wire hsg_sample_t dc_sample = {act_level, 8'h00};
    wire hsg_sample_t neg_sample = dc_sample == 16'sh8000 ? 16'sh7fff : -dc_sample;
    wire hsg_sample_t gen_sample = act_sel && tone_pol ? neg_sample : dc_sample;

    // sample pacing; the generator stalls while the fifo is full
    logic [15:0] rate_cnt;
    logic smp_valid;
    hsg_sample_t smp_data;
    wire fifo_in_ready;
    wire rate_done = rate_cnt >= vibe_sample_rate_sel;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rate_cnt <= 16'h0000;
            smp_valid <= 1'b0;
            smp_data <= 16'sh0000;
        end else begin
            rate_cnt <= rate_done ? 16'h0000 : rate_cnt + 16'h0001;
            if (rate_done && (!smp_valid || fifo_in_ready)) begin
                smp_valid <= 1'b1;
                smp_data <= gen_sample;
            end else if (fifo_in_ready) begin
                smp_valid <= 1'b0;
            end
        end
    end

    wire [15:0] fifo_out_data;
    wire fifo_out_valid;
    wire out_take = !mix_valid || mix_ready;

    hsg_fifo #(.WIDTH(16), .DEPTH(16)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(smp_data),
        .in_valid(smp_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(out_take)
    );

    // output stage keeps the mixer port on flip-flops
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mix_valid <= 1'b0;
            mix_data <= 16'sh0000;
        end else if (out_take) begin
            mix_valid <= fifo_out_valid;
            mix_data <= fifo_out_data;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ack_one_cycle: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single cycle");
    a_trig_starts: assert property (trig_go |=> state == HSG_PH1 && profile_active_flag)
        else $error("trigger did not start profile");
    a_trig_ignored: assert property (trig_wr && vibe_mode_select != HSG_MODE_SHOT |=> !profile_active_flag)
        else $error("trigger honoured outside one-shot");
    a_phase_order: assert property (state == HSG_PH1 && vibe_mode_select == HSG_MODE_SHOT && !trig_go
        |=> state inside {HSG_PH1, HSG_PH2})
        else $error("phase one left wrongly");
    a_end_idle: assert property (state == HSG_PH3 && steps_left == 11'h000 && !trig_go |=> state == HSG_IDLE)
        else $error("profile did not end");
    a_idle_zero: assert property (vibe_mode_select == HSG_MODE_SHOT && state == HSG_IDLE |-> act_level == 8'h00)
        else $error("idle level not zero");
    a_cont_level: assert property (vibe_mode_select == HSG_MODE_CONT |-> act_level == middle_stage_level)
        else $error("continuous level wrong");
    a_off_zero: assert property (vibe_mode_select == HSG_MODE_OFF |-> gen_sample == 16'sh0000)
        else $error("disabled output not zero");
    a_dc_steady: assert property (!act_sel |-> gen_sample == dc_sample)
        else $error("rotating mass output not dc");
    a_tone_flip: assert property (half_done && act_sel |=> tone_pol != $past(tone_pol))
        else $error("tone did not flip");
    a_zero_phase: assert property (state == HSG_PH2 && steps_left == 11'h000 && !trig_go
        && vibe_mode_select == HSG_MODE_SHOT |=> state == HSG_PH3)
        else $error("zero length phase stalled");

    c_oneshot: cover property (state == HSG_PH3 ##1 state == HSG_IDLE);
    c_retrig: cover property (profile_active_flag && trig_go);
    c_fifo_full: cover property (smp_valid && !fifo_in_ready);
    c_tone: cover property (act_sel && half_done);
endmodule

`default_nettype wire

// >>> bench/hsg_mixer_model.sv
/*
  output mixer model: drains the haptic sample stream, keeps the last
  accepted sample and counts value changes.
  assumes clk_sys and rst_n shared with the generator.
*/
`include "hsg_map.svh"
`timescale 1ns/100ps
`default_nettype none
module hsg_mixer_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // sample stream from the generator
    input wire hsg_pkg::hsg_sample_t mix_data,
    input wire logic mix_valid,
    output logic mix_ready,
    // bench controls and observations
    input wire logic stall,
    input wire logic slow,
    input wire logic clear,
    output hsg_pkg::hsg_sample_t last_sample,
    output logic [15:0] flips
);
    import hsg_pkg::*;
    localparam logic [7:0] mixer_source_select = `HSG_MIXER_SRC;
    logic pace;
    logic routed;
    logic taken;
    assign routed = (mixer_source_select == 8'h06);
    // same rate on both sides, so no conversion
    assign mix_ready = routed && !stall && (!slow || pace);
    assign taken = mix_valid && mix_ready;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pace <= 1'b0;
            last_sample <= '0;
            flips <= '0;
        end else begin
            pace <= !pace;
            if (clear) begin
                flips <= '0;
            end else if (taken && mix_data !== last_sample) begin
                flips <= flips + 16'h1;
            end
            if (taken) begin
                last_sample <= mix_data;
            end
        end
    end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
/*
  testbench of the haptic signal generator: wishbone register tasks,
  sequences of register accesses checked against the samples the mixer sees.
  assumes STEP_CYCLES shortened to 4 so phase lengths stay short.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import hsg_pkg::*;
    logic clk_sys, rst_n, cyc, stb, we, mix_valid, mix_ready, stall, slow, clear, wb_ack_o;
    logic [9:0] adr;
    logic [3:0] sel, lanes;
    logic [31:0] wdat, wb_dat_o;
    logic [15:0] rd, flips;
    hsg_sample_t mix_data, last_sample, held;
    int errors, cmp_count, i;
    localparam logic [15:0] rst_val [0:9] = '{16'h0, 16'h7fff, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0,
        16'h0, 16'h00d0};
    localparam logic [15:0] wr_mask [0:8] = '{16'h0, 16'h7fff, 16'h00ff, 16'h01ff, 16'h00ff, 16'h07ff,
        16'h00ff, 16'h01ff, 16'h0};

    hsg_top #(.STEP_CYCLES(4)) hsg_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .mix_data(mix_data), .mix_valid(mix_valid), .mix_ready(mix_ready));
    hsg_mixer_model hsg_mixer_model_inst (.clk_sys(clk_sys), .rst_n(rst_n), .mix_data(mix_data),
        .mix_valid(mix_valid), .mix_ready(mix_ready), .stall(stall), .slow(slow), .clear(clear),
        .last_sample(last_sample), .flips(flips));

    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check16(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: register %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic check_smp(input hsg_sample_t exp);
        cmp_count++;
        if (last_sample !== exp) begin
            errors++;
            $display("unexpected at %0t: sample %h, expected %h", $time, last_sample, exp);
        end
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one classic cycle; ack and read data are taken at the same edge
    task automatic wb_xfer(input logic wr, input logic [7:0] idx, input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        sel <= lanes;
        adr <= {idx, 2'h0};
        wdat <= {16'h0, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        if (n >= 100) begin
            errors++;
            $display("unexpected at %0t: bus timeout", $time);
        end
        q = wb_dat_o[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        #(100 * 30000);
        $display("unexpected at %0t: watchdog expired", $time);
        errors++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        {cyc, stb, we, stall, slow, clear} = '0;
        adr = '0;
        sel = '0;
        lanes = 4'h3;
        wdat = '0;
        errors = 0;
        cmp_count = 0;
        wait_clk(3);
        rst_n <= 1'b1;
        wait_clk(1);
        for (i = 0; i < 10; i++) begin
            wb_xfer(1'b0, 8'h90 + 8'(i), 16'h0, rd);
            check16(rd, rst_val[i]);
        end
        for (i = 1; i < 9; i++) begin
            wb_xfer(1'b1, 8'h90 + 8'(i), 16'hffff, rd);
            wb_xfer(1'b0, 8'h90 + 8'(i), 16'h0, rd);
            check16(rd, wr_mask[i]);
        end
        // byte lanes: only the enabled bytes change
        lanes = 4'h1;
        wb_xfer(1'b1, 8'h91, 16'h0000, rd);
        lanes = 4'h2;
        wb_xfer(1'b1, 8'h93, 16'h0000, rd);
        wb_xfer(1'b1, 8'h90, 16'h0011, rd);
        lanes = 4'h3;
        wb_xfer(1'b0, 8'h91, 16'h0, rd);
        check16(rd, 16'h7f00);
        wb_xfer(1'b0, 8'h93, 16'h0, rd);
        check16(rd, 16'h00ff);
        wb_xfer(1'b0, 8'h90, 16'h0, rd);
        check16(rd, 16'h0);
        // unmapped place: write dropped, reads zero
        wb_xfer(1'b1, 8'h9a, 16'hffff, rd);
        wb_xfer(1'b0, 8'h9a, 16'h0, rd);
        check16(rd, 16'h0);
        wb_xfer(1'b1, 8'h90, 16'h0011, rd);
        wb_xfer(1'b0, 8'h90, 16'h0, rd);
        check16(rd, 16'h0001);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h0);
        wb_xfer(1'b1, 8'h99, 16'h0003, rd);
        wb_xfer(1'b1, 8'h92, 16'h0010, rd);
        wb_xfer(1'b1, 8'h94, 16'h0040, rd);
        wb_xfer(1'b1, 8'h96, 16'h0020, rd);
        for (i = 0; i < 4; i++) begin
            wb_xfer(1'b1, 8'h90, 16'(i * 4), rd);
            wait_clk(40);
            check_smp(i == 1 ? 16'sh4000 : 16'sh0000);
        end
        wb_xfer(1'b1, 8'h90, 16'h0014, rd);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h0);
        wb_xfer(1'b1, 8'h94, 16'h00c0, rd);
        wait_clk(40);
        check_smp(16'shc000);
        // fifo fills while the mixer stalls; the held word must not move
        wb_xfer(1'b1, 8'h94, 16'h0040, rd);
        stall <= 1'b1;
        wait_clk(120);
        held = mix_data;
        wait_clk(20);
        check16(mix_data, held);
        check16({15'h0, mix_valid}, 16'h1);
        wb_xfer(1'b1, 8'h94, 16'h0020, rd);
        stall <= 1'b0;
        wait_clk(150);
        check_smp(16'sh2000);
        // one-shot profile against a slow mixer
        slow <= 1'b1;
        wb_xfer(1'b1, 8'h92, 16'h0030, rd);
        wb_xfer(1'b1, 8'h94, 16'h00d0, rd);
        wb_xfer(1'b1, 8'h96, 16'h0010, rd);
        for (i = 0; i < 3; i++) begin
            wb_xfer(1'b1, 8'h93 + 8'(i * 2), 16'd20, rd);
        end
        wb_xfer(1'b1, 8'h90, 16'h0008, rd);
        wb_xfer(1'b1, 8'h90, 16'h0018, rd);
        wait_clk(40);
        check_smp(16'sh3000);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h1);
        wait_clk(78);
        check_smp(16'shd000);
        wait_clk(81);
        check_smp(16'sh1000);
        wait_clk(50);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h0);
        wait_clk(20);
        check_smp(16'sh0000);
        // trigger again from idle, then abort by leaving one-shot mode
        wb_xfer(1'b1, 8'h90, 16'h0018, rd);
        wait_clk(20);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h1);
        wb_xfer(1'b1, 8'h90, 16'h0004, rd);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h0);
        for (i = 0; i < 3; i++) begin
            wb_xfer(1'b1, 8'h93 + 8'(i * 2), 16'h0, rd);
        end
        // mode must already read one-shot for the trigger to count
        wb_xfer(1'b1, 8'h90, 16'h0008, rd);
        wb_xfer(1'b1, 8'h90, 16'h0018, rd);
        wait_clk(10);
        wb_xfer(1'b0, 8'h98, 16'h0, rd);
        check16(rd, 16'h0);
        // resonant tone: half period of 6 base ticks, about 102 changes in 1000 clocks
        slow <= 1'b0;
        wb_xfer(1'b1, 8'h99, 16'h0000, rd);
        wb_xfer(1'b1, 8'h91, 16'h0005, rd);
        for (i = 0; i < 2; i++) begin
            wb_xfer(1'b1, 8'h94, i == 0 ? 16'h0040 : 16'h00c0, rd);
            wb_xfer(1'b1, 8'h90, 16'h0005, rd);
            clear <= 1'b1;
            wait_clk(1);
            clear <= 1'b0;
            wait_clk(1000);
            check16({15'h0, flips >= 16'd99 && flips <= 16'd105}, 16'h1);
            check16({15'h0, last_sample === 16'sh4000 || last_sample === 16'shc000}, 16'h1);
            wb_xfer(1'b1, 8'h90, 16'h0004, rd);
            wait_clk(20);
            clear <= 1'b1;
            wait_clk(1);
            clear <= 1'b0;
            wait_clk(100);
            check16(flips, 16'h0);
        end
        // 250 Hz setting: half period far beyond the window, at most one change
        wb_xfer(1'b1, 8'h91, 16'h2fff, rd);
        wb_xfer(1'b1, 8'h90, 16'h0005, rd);
        clear <= 1'b1;
        wait_clk(1);
        clear <= 1'b0;
        wait_clk(1000);
        check16({15'h0, flips <= 16'd1}, 16'h1);
        finish_test();
    end
endmodule
`default_nettype wire
